// ===== logic/ccr_pkg.sv
package ccr_pkg;
   // ***********************************************
   // Command word fields
   // ***********************************************
   localparam int DEV_ADDR_HI = 15;
   localparam int DEV_ADDR_LO = 13;
   localparam int RW_BIT = 12;
   localparam int REG_ADDR_HI = 11;
   localparam int REG_ADDR_LO = 9;
   localparam int DATA_HI = 7;
   localparam int DATA_LO = 0;
   localparam logic [2:0] STANDALONE_ADDR = 3'h0;
   // ***********************************************
   // Register numbers and reset values
   // ***********************************************
   localparam logic [2:0] REG_NOP = 3'h0;
   localparam logic [2:0] REG_INPUT_PATH = 3'h1;
   localparam logic [2:0] REG_POWER_CLOCK = 3'h2;
   localparam logic [2:0] REG_TEST_CHANNEL = 3'h3;
   localparam logic [2:0] REG_GAIN = 3'h4;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // ***********************************************
   // Control 1 bits
   // ***********************************************
   localparam int C1_OVF = 7;
   localparam int C1_RX_AMP = 6;
   localparam int C1_AAF_BYP = 5;
   localparam int C1_AUX_SEL = 4;
   localparam int C1_SW_RESET = 3;
   localparam int C1_FIR_BYP = 2;
   localparam int C1_TX_AMP = 1;
   localparam int C1_DAC16 = 0;
   // ***********************************************
   // Control 2 bits
   // ***********************************************
   localparam int C2_LOW_POWER = 7;
   localparam int C2_MOD_STOP = 6;
   localparam int C2_RSVD = 5;
   localparam logic [5:0] DIV_WHEN_ZERO = 6'h20;
   // ***********************************************
   // Control 3 bits
   // ***********************************************
   localparam int C3_MODE_HI = 7;
   localparam int C3_MODE_LO = 6;
   localparam int C3_CONT = 5;
   localparam int C3_FLAG_SRC = 4;
   localparam int C3_FLAG_VAL = 3;
   localparam int C3_CHAN_HI = 2;
   localparam int C3_CHAN_LO = 1;
   localparam int C3_ADC16 = 0;
   localparam logic [1:0] MODE_EVENT = 2'h3;
   localparam logic [1:0] CHAN_ADC_OFF = 2'h1;
   localparam logic [1:0] CHAN_DAC_OFF = 2'h2;
   localparam logic [1:0] CHAN_PWR_DOWN = 2'h3;
   localparam logic [3:0] GAIN_MUTE = 4'hf;
endpackage

// ===== logic/ccr_bank.sv
`timescale 1ns/1ns
module ccr_bank (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic cmd_valid_in,
   input wire logic [15:0] cmd_word_in,
   input wire logic [2:0] own_addr_in,
   input wire logic cascade_master_in,
   input wire logic overflow_in,
   input wire logic comm_flag_in,
   output logic rd_valid_out,
   output logic [15:0] rd_word_out,
   output logic soft_reset_out,
   output logic rx_amp_en_out,
   output logic aux_input_sel_out,
   output logic aaf_bypass_out,
   output logic fir_bypass_out,
   output logic tx_amp_en_out,
   output logic dac_16bit_out,
   output logic low_power_out,
   output logic mod_stop_out,
   output logic [5:0] clk_div_out,
   output logic analog_loop_out,
   output logic digital_loop_out,
   output logic event_monitor_out,
   output logic cont_xfer_out,
   output logic flag_pin_out,
   output logic adc_en_out,
   output logic dac_en_out,
   output logic power_down_out,
   output logic adc_16bit_out,
   output logic [3:0] adc_gain_out,
   output logic [3:0] dac_gain_out,
   output logic adc_mute_out,
   output logic dac_mute_out
);
   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] c3;
      logic [7:0] c4;
      logic ovf;
      logic srst;
      logic rd_valid;
      logic [15:0] rd_word;
      logic rx_amp;
      logic aux_sel;
      logic aaf_byp;
      logic fir_byp;
      logic tx_amp;
      logic dac16;
      logic low_pwr;
      logic mod_stop;
      logic [5:0] div;
      logic aloop;
      logic dloop;
      logic evmon;
      logic cont;
      logic flag;
      logic adc_en;
      logic dac_en;
      logic pdn;
      logic adc16;
      logic [3:0] again;
      logic [3:0] dgain;
      logic amute;
      logic dmute;
   } ccr_state_s;

   ccr_state_s st_q;
   ccr_state_s st_d;

   // Decoded divider value, zero field means 32
   function automatic logic [5:0] ccr_div(input logic [4:0] f);
      ccr_div = (f == 5'h00) ? ccr_pkg::DIV_WHEN_ZERO : {1'b0, f};
   endfunction

   logic addr_hit;
   logic is_write;
   logic [2:0] reg_no;
   logic [7:0] payload;
   logic [7:0] rd_data;
   logic [7:0] c3_eff;

   // ***********************************************
   // Command decode
   // ***********************************************
   always_comb begin
      // Stand-alone parts are strapped to address 000
      addr_hit = cmd_valid_in &&
         (cmd_word_in[ccr_pkg::DEV_ADDR_HI:ccr_pkg::DEV_ADDR_LO] == own_addr_in);
      is_write = !cmd_word_in[ccr_pkg::RW_BIT];
      reg_no = cmd_word_in[ccr_pkg::REG_ADDR_HI:ccr_pkg::REG_ADDR_LO];
      payload = cmd_word_in[ccr_pkg::DATA_HI:ccr_pkg::DATA_LO];
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      st_d = st_q;
      st_d.rd_valid = 1'b0;
      st_d.srst = 1'b0;
      // Overflow is sticky until control 1 is read; a new event wins
      if (addr_hit && !is_write && reg_no == ccr_pkg::REG_INPUT_PATH) begin
         st_d.ovf = 1'b0;
      end
      if (overflow_in) begin
         st_d.ovf = 1'b1;
      end
      rd_data = 8'h00;
      case (reg_no)
         ccr_pkg::REG_INPUT_PATH: rd_data = {st_q.ovf, st_q.c1[6:0]};
         ccr_pkg::REG_POWER_CLOCK: rd_data = st_q.c2;
         ccr_pkg::REG_TEST_CHANNEL: rd_data = st_q.c3;
         ccr_pkg::REG_GAIN: rd_data = st_q.c4;
         default: rd_data = 8'h00;
      endcase
      if (addr_hit && is_write) begin
         case (reg_no)
            ccr_pkg::REG_INPUT_PATH: begin
               st_d.c1 = {1'b0, payload[6:4], 1'b0, payload[2:0]};
               st_d.srst = payload[ccr_pkg::C1_SW_RESET];
            end
            ccr_pkg::REG_POWER_CLOCK: begin
               st_d.c2 = payload;
               st_d.c2[ccr_pkg::C2_RSVD] = 1'b0;
            end
            ccr_pkg::REG_TEST_CHANNEL: st_d.c3 = payload;
            ccr_pkg::REG_GAIN: st_d.c4 = payload;
            default: st_d.c1 = st_q.c1;
         endcase
      end else if (addr_hit) begin
         st_d.rd_valid = 1'b1;
         st_d.rd_word = {cmd_word_in[15:8], rd_data};
      end
      // Software reset restores every control register
      if (st_q.srst) begin
         st_d.c1 = ccr_pkg::RESET_VALUE;
         st_d.c2 = ccr_pkg::RESET_VALUE;
         st_d.c3 = ccr_pkg::RESET_VALUE;
         st_d.c4 = ccr_pkg::RESET_VALUE;
      end
      c3_eff = st_d.c3;
      st_d.rx_amp = st_d.c1[ccr_pkg::C1_RX_AMP];
      st_d.aux_sel = st_d.c1[ccr_pkg::C1_AUX_SEL] | st_d.c1[ccr_pkg::C1_RX_AMP];
      st_d.aaf_byp = st_d.c1[ccr_pkg::C1_AAF_BYP];
      st_d.fir_byp = st_d.c1[ccr_pkg::C1_FIR_BYP];
      st_d.tx_amp = st_d.c1[ccr_pkg::C1_TX_AMP];
      st_d.dac16 = st_d.c1[ccr_pkg::C1_DAC16];
      st_d.low_pwr = st_d.c2[ccr_pkg::C2_LOW_POWER];
      st_d.mod_stop = st_d.c2[ccr_pkg::C2_MOD_STOP];
      st_d.div = ccr_div(st_d.c2[4:0]);
      st_d.aloop = c3_eff[7:6] == 2'h1;
      st_d.dloop = c3_eff[7:6] == 2'h2;
      // Event monitor only takes effect during write cycles
      st_d.evmon = (c3_eff[7:6] == ccr_pkg::MODE_EVENT) && addr_hit && is_write;
      st_d.cont = c3_eff[ccr_pkg::C3_CONT] && cascade_master_in;
      st_d.flag = c3_eff[ccr_pkg::C3_FLAG_SRC] ? c3_eff[ccr_pkg::C3_FLAG_VAL]
                                              : comm_flag_in;
      st_d.pdn = c3_eff[2:1] == ccr_pkg::CHAN_PWR_DOWN;
      st_d.adc_en = !(c3_eff[2:1] == ccr_pkg::CHAN_ADC_OFF) && !st_d.pdn;
      st_d.dac_en = !(c3_eff[2:1] == ccr_pkg::CHAN_DAC_OFF) && !st_d.pdn;
      st_d.adc16 = c3_eff[ccr_pkg::C3_ADC16];
      st_d.again = st_d.c4[7:4];
      st_d.dgain = st_d.c4[3:0];
      st_d.amute = st_d.c4[7:4] == ccr_pkg::GAIN_MUTE;
      st_d.dmute = st_d.c4[3:0] == ccr_pkg::GAIN_MUTE;
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
         st_q.div <= ccr_pkg::DIV_WHEN_ZERO;
         st_q.adc_en <= 1'b1;
         st_q.dac_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign rd_valid_out = st_q.rd_valid;
   assign rd_word_out = st_q.rd_word;
   assign soft_reset_out = st_q.srst;
   assign rx_amp_en_out = st_q.rx_amp;
   assign aux_input_sel_out = st_q.aux_sel;
   assign aaf_bypass_out = st_q.aaf_byp;
   assign fir_bypass_out = st_q.fir_byp;
   assign tx_amp_en_out = st_q.tx_amp;
   assign dac_16bit_out = st_q.dac16;
   assign low_power_out = st_q.low_pwr;
   assign mod_stop_out = st_q.mod_stop;
   assign clk_div_out = st_q.div;
   assign analog_loop_out = st_q.aloop;
   assign digital_loop_out = st_q.dloop;
   assign event_monitor_out = st_q.evmon;
   assign cont_xfer_out = st_q.cont;
   assign flag_pin_out = st_q.flag;
   assign adc_en_out = st_q.adc_en;
   assign dac_en_out = st_q.dac_en;
   assign power_down_out = st_q.pdn;
   assign adc_16bit_out = st_q.adc16;
   assign adc_gain_out = st_q.again;
   assign dac_gain_out = st_q.dgain;
   assign adc_mute_out = st_q.amute;
   assign dac_mute_out = st_q.dmute;

   // ***********************************************
   // Checks
   // ***********************************************
   property p_addr_match;
      @(posedge clock_in) disable iff (!arst_n_in)
      (cmd_valid_in && cmd_word_in[12] && cmd_word_in[15:13] != own_addr_in)
         |=> !rd_valid_out;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("read answered wrong address");

   property p_read_echo;
      @(posedge clock_in) disable iff (!arst_n_in)
      (addr_hit && !is_write) |=> rd_valid_out && rd_word_out[15:8] == $past(cmd_word_in[15:8]);
   endproperty
   a_read_echo: assert property (p_read_echo) else $error("read answer malformed");

   property p_write_gain;
      @(posedge clock_in) disable iff (!arst_n_in)
      (addr_hit && is_write && reg_no == ccr_pkg::REG_GAIN && !st_q.srst)
         |=> {adc_gain_out, dac_gain_out} == $past(payload);
   endproperty
   a_write_gain: assert property (p_write_gain) else $error("gain write lost");

   property p_srst_pulse;
      @(posedge clock_in) disable iff (!arst_n_in)
      soft_reset_out |=> !soft_reset_out || $past(addr_hit && is_write);
   endproperty
   a_srst_pulse: assert property (p_srst_pulse) else $error("reset bit stuck");

   property p_aux_force;
      @(posedge clock_in) disable iff (!arst_n_in)
      rx_amp_en_out |-> aux_input_sel_out;
   endproperty
   a_aux_force: assert property (p_aux_force) else $error("aux not forced");

   property p_div_zero;
      @(posedge clock_in) disable iff (!arst_n_in)
      (st_q.c2[4:0] == 5'h00) |-> clk_div_out == 6'h20;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("divider zero wrong");

   property p_ovf_sticky;
      @(posedge clock_in) disable iff (!arst_n_in)
      overflow_in |=> st_q.ovf;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

   property p_pdn;
      @(posedge clock_in) disable iff (!arst_n_in)
      power_down_out |-> !adc_en_out && !dac_en_out;
   endproperty
   a_pdn: assert property (p_pdn) else $error("power down leaves channels on");

   property p_cont_master;
      @(posedge clock_in) disable iff (!arst_n_in)
      cont_xfer_out |-> $past(cascade_master_in);
   endproperty
   a_cont_master: assert property (p_cont_master) else $error("continuous on slave");

   property p_evmon_write;
      @(posedge clock_in) disable iff (!arst_n_in)
      event_monitor_out |-> $past(addr_hit && is_write);
   endproperty
   a_evmon_write: assert property (p_evmon_write) else $error("monitor without write");

   c_read: cover property (@(posedge clock_in) disable iff (!arst_n_in) rd_valid_out);
   c_srst: cover property (@(posedge clock_in) disable iff (!arst_n_in) soft_reset_out);
   c_evmon: cover property (@(posedge clock_in) disable iff (!arst_n_in) event_monitor_out);
   c_ovf_race: cover property (@(posedge clock_in) disable iff (!arst_n_in)
      overflow_in && addr_hit && !is_write && reg_no == ccr_pkg::REG_INPUT_PATH);
endmodule

// ===== tb/ccr_host.sv
`timescale 1ns/1ns
module ccr_host (
   input wire logic clock_in,
   output logic cmd_valid_out,
   output logic [15:0] cmd_word_out
);
   // ***********************************************
   // Command issue
   // ***********************************************
   initial begin
      cmd_valid_out = 1'b0;
      cmd_word_out = 16'h0000;
   end

   // Word is inverted when idle so no stale value lingers
   task automatic send(input logic [2:0] dev, input logic rd, input logic [2:0] rno,
         input logic [7:0] data);
      @(posedge clock_in);
      #1;
      cmd_valid_out = 1'b1;
      cmd_word_out = {dev, rd, rno, 1'b0, data};
      @(posedge clock_in);
      #1;
      cmd_valid_out = 1'b0;
      cmd_word_out = ~cmd_word_out;
   endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic cmd_valid_in, rd_valid_out, soft_reset_out, rx_amp_en_out, aux_input_sel_out;
   logic [15:0] cmd_word_in, rd_word_out;
   logic [2:0] own_addr_in = 3'h0;
   logic [2:0] dev = 3'h0;
   logic cascade_master_in = 1'b0;
   logic overflow_in = 1'b0;
   logic comm_flag_in = 1'b0;
   logic aaf_bypass_out, fir_bypass_out, tx_amp_en_out, dac_16bit_out, low_power_out;
   logic mod_stop_out, analog_loop_out, digital_loop_out, event_monitor_out, cont_xfer_out;
   logic flag_pin_out, adc_en_out, dac_en_out, power_down_out, adc_16bit_out;
   logic adc_mute_out, dac_mute_out;
   logic [5:0] clk_div_out;
   logic [3:0] adc_gain_out, dac_gain_out;
   int n_mismatch = 0;
   int n_tests = 0;

   always #4 clock_in = ~clock_in;

   ccr_host i_host (.clock_in(clock_in), .cmd_valid_out(cmd_valid_in),
      .cmd_word_out(cmd_word_in));

   ccr_bank i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in),
      .cmd_word_in(cmd_word_in), .own_addr_in(own_addr_in),
      .cascade_master_in(cascade_master_in), .overflow_in(overflow_in),
      .comm_flag_in(comm_flag_in), .rd_valid_out(rd_valid_out), .rd_word_out(rd_word_out),
      .soft_reset_out(soft_reset_out), .rx_amp_en_out(rx_amp_en_out),
      .aux_input_sel_out(aux_input_sel_out), .aaf_bypass_out(aaf_bypass_out),
      .fir_bypass_out(fir_bypass_out), .tx_amp_en_out(tx_amp_en_out),
      .dac_16bit_out(dac_16bit_out), .low_power_out(low_power_out),
      .mod_stop_out(mod_stop_out), .clk_div_out(clk_div_out),
      .analog_loop_out(analog_loop_out), .digital_loop_out(digital_loop_out),
      .event_monitor_out(event_monitor_out), .cont_xfer_out(cont_xfer_out),
      .flag_pin_out(flag_pin_out), .adc_en_out(adc_en_out), .dac_en_out(dac_en_out),
      .power_down_out(power_down_out), .adc_16bit_out(adc_16bit_out),
      .adc_gain_out(adc_gain_out), .dac_gain_out(dac_gain_out),
      .adc_mute_out(adc_mute_out), .dac_mute_out(dac_mute_out));

   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick;
      @(posedge clock_in);
      #1;
   endtask

   task automatic wr(input logic [2:0] r, input logic [7:0] v);
      i_host.send(dev, 1'b0, r, v);
   endtask

   task automatic rd(input logic [2:0] r, input logic [7:0] exp);
      i_host.send(dev, 1'b1, r, 8'h00);
      chk(rd_valid_out, dev == own_addr_in);
      if (dev == own_addr_in) chk(rd_word_out, {dev, 1'b1, r, 1'b0, exp});
   endtask

   task automatic c1_chk(input logic [5:0] exp);
      chk({rx_amp_en_out, aux_input_sel_out, aaf_bypass_out, fir_bypass_out,
         tx_amp_en_out, dac_16bit_out}, exp);
   endtask

   task automatic end_sim;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_reset;
      chk({clk_div_out, adc_en_out, dac_en_out, power_down_out, low_power_out}, 10'h20c);
      c1_chk(6'h00);
      for (int r = 1; r <= 4; r++) rd(r[2:0], 8'h00);
   endtask

   task automatic t_ctrl1;
      wr(3'h1, 8'h77);
      c1_chk(6'h3f);
      chk(soft_reset_out, 1'b0);
      rd(3'h1, 8'h77);
      wr(3'h1, 8'h10);
      c1_chk(6'h10);
      wr(3'h1, 8'h40);
      c1_chk(6'h30);
      wr(3'h1, 8'h25);
      c1_chk(6'h0d);
      wr(3'h1, 8'h02);
      c1_chk(6'h02);
   endtask

   task automatic t_ctrl2;
      wr(3'h2, 8'hdf);
      chk({low_power_out, mod_stop_out, clk_div_out}, 8'hdf);
      wr(3'h2, 8'he1);
      chk({low_power_out, mod_stop_out, clk_div_out}, 8'hc1);
      rd(3'h2, 8'hc1);
      wr(3'h2, 8'h00);
      chk({low_power_out, mod_stop_out, clk_div_out}, 8'h20);
   endtask

   task automatic t_sreset;
      wr(3'h2, 8'h81);
      wr(3'h1, 8'h0b);
      chk(soft_reset_out, 1'b1);
      tick();
      chk(soft_reset_out, 1'b0);
      rd(3'h1, 8'h00);
      rd(3'h2, 8'h00);
      chk({low_power_out, clk_div_out}, 7'h20);
   endtask

   task automatic t_ovf;
      tick();
      overflow_in = 1'b1;
      tick();
      overflow_in = 1'b0;
      rd(3'h1, 8'h80);
      rd(3'h1, 8'h00);
      // New event in the clearing read must survive
      overflow_in = 1'b1;
      rd(3'h1, 8'h80);
      overflow_in = 1'b0;
      rd(3'h1, 8'h80);
      rd(3'h1, 8'h00);
   endtask

   task automatic t_ctrl3;
      for (int m = 0; m < 4; m++) begin
         wr(3'h3, {m[1:0], 6'h00});
         chk({analog_loop_out, digital_loop_out, event_monitor_out},
            {m == 1, m == 2, m == 3});
         tick();
         chk(event_monitor_out, 1'b0);
         if (m == 3) begin
            rd(3'h3, 8'hc0);
            chk(event_monitor_out, 1'b0);
         end
      end
      for (int c = 0; c < 4; c++) begin
         wr(3'h3, {5'h00, c[1:0], c[0]});
         chk({power_down_out, adc_16bit_out}, {c == 3, c[0]});
         chk({adc_en_out, dac_en_out}, {c == 0 || c == 2, c == 0 || c == 1});
      end
      wr(3'h3, 8'h20);
      chk(cont_xfer_out, 1'b0);
      cascade_master_in = 1'b1;
      tick();
      chk(cont_xfer_out, 1'b1);
      wr(3'h3, 8'h18);
      chk(flag_pin_out, 1'b1);
      wr(3'h3, 8'h10);
      chk(flag_pin_out, 1'b0);
      wr(3'h3, 8'h08);
      chk(flag_pin_out, 1'b0);
      comm_flag_in = 1'b1;
      tick();
      chk(flag_pin_out, 1'b1);
      rd(3'h3, 8'h08);
   endtask

   task automatic t_ctrl4;
      logic [7:0] v[3] = '{8'hf0, 8'h0f, 8'h5a};
      foreach (v[i]) begin
         wr(3'h4, v[i]);
         chk({adc_gain_out, dac_gain_out, adc_mute_out, dac_mute_out},
            {v[i], v[i][7:4] == 4'hf, v[i][3:0] == 4'hf});
         rd(3'h4, v[i]);
      end
   endtask

   task automatic t_addr;
      own_addr_in = 3'h3;
      dev = 3'h2;
      wr(3'h4, 8'h11);
      rd(3'h4, 8'h00);
      dev = 3'h3;
      chk({adc_gain_out, dac_gain_out}, 8'h5a);
      wr(3'h4, 8'h22);
      chk({adc_gain_out, dac_gain_out}, 8'h22);
      wr(3'h0, 8'h33);
      rd(3'h5, 8'h00);
      chk({adc_gain_out, dac_gain_out}, 8'h22);
      own_addr_in = 3'h0;
      dev = 3'h0;
      wr(3'h4, 8'h44);
      chk({adc_gain_out, dac_gain_out}, 8'h44);
   endtask

   task automatic t_rst2;
      tick();
      arst_n_in = 1'b0;
      tick();
      arst_n_in = 1'b1;
      chk({adc_gain_out, dac_gain_out, flag_pin_out, cont_xfer_out}, 10'h000);
      t_reset();
   endtask

   // ***********************************************
   // Main sequence and watchdog
   // ***********************************************
   initial begin
      repeat (4) @(posedge clock_in);
      #1;
      arst_n_in = 1'b1;
      t_reset();
      t_ctrl1();
      t_ctrl2();
      t_sreset();
      t_ovf();
      t_ctrl3();
      t_ctrl4();
      t_addr();
      t_rst2();
      end_sim();
   end

   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule
